// [pkg/sbg_defines.svh]
// Purpose: offsets, field positions, reset values and counts for the serial port clock/status block
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef SBG_DEFINES_SVH
`define SBG_DEFINES_SVH

`define SBG_OFF_STAT 3'h0
`define SBG_OFF_CON1 3'h1
`define SBG_OFF_RELOAD 3'h2
`define SBG_OFF_BUF 3'h3

`define SBG_STAT_SMP 7
`define SBG_STAT_CKE 6
`define SBG_CON1_WRITE_COLLISION 7
`define SBG_CON1_OVF 6
`define SBG_CON1_EN 5
`define SBG_CON1_CKP 4

`define SBG_STAT_RST 8'h00
`define SBG_CON1_RST 8'h00
`define SBG_RELOAD_RST 8'h00

`define SBG_DIV4_RELOAD 8'h00
`define SBG_DIV16_RELOAD 8'h03
`define SBG_DIV64_RELOAD 8'h0f

`define SBG_SPI_LAST_EDGE 5'h0f
`define SBG_SPI_DONE_EDGE 5'h10
`define SBG_BYTE_LAST_BIT 3'h7

`endif

// [pkg/sbg_pkg.sv]
// Purpose: types shared by the serial port clock/status block
// Assumes: nothing
// Notes: mode codes follow the 4-bit mode field
package sbg_pkg;

    typedef enum logic [3:0] {
        SBG_M_SPI_DIV4 = 4'h0,
        SBG_M_SPI_DIV16 = 4'h1,
        SBG_M_SPI_DIV64 = 4'h2,
        SBG_M_SPI_T2 = 4'h3,
        SBG_M_SPI_SLV_SS = 4'h4,
        SBG_M_SPI_SLV_NOSS = 4'h5,
        SBG_M_I2C_S7 = 4'h6,
        SBG_M_I2C_S10 = 4'h7,
        SBG_M_I2C_MHW = 4'h8,
        SBG_M_RSV9 = 4'h9,
        SBG_M_SPI_BRG = 4'ha,
        SBG_M_I2C_MFW = 4'hb,
        SBG_M_RSVC = 4'hc,
        SBG_M_RSVD = 4'hd,
        SBG_M_I2C_S7SP = 4'he,
        SBG_M_I2C_S10SP = 4'hf
    } sbg_mode_t;

    typedef enum logic [1:0] {
        SBG_SPI_IDLE = 2'b01,
        SBG_SPI_SHIFT = 2'b10
    } sbg_spi_state_t;

endpackage

// [core/sbg_port.sv]
// Purpose: baud counter, status and first control register of the synchronous serial port
// Assumes: I2C byte engine and start/stop detector run on MCLK and report by one-cycle pulses
// Notes: SPI shifting is done here; I2C bit timing beyond the serial clock is outside
// How it works
// - I2C master and reload SPI master clock is oscillator over four times reload plus one.
// - one serial clock period equals two reload counter rollovers.
// - SPI master samples at end of output time if phase bit set, else middle.
// - SPI shifts out on active-to-idle if edge bit set, else idle-to-active.
// - clock polarity bit sets SPI clock idle level.
// - I2C data-not-address flag follows the type of the last byte.
// - start-seen and stop-seen flags record the last bus condition.
// - start-seen and stop-seen are zero after reset and while disabled.
// - I2C slave keeps matched direction bit until start, stop or not-acknowledge.
// - I2C master direction bit shows transmit; idle when it and requests are zero.
// - ten-bit slave sets address-update flag when the address needs rewriting.
// - buffer-full sets on completed reception and clears when buffer empties.
// - I2C transmit keeps buffer-full set only while data bits are sent.
// - buffer write during transmission sets write collision; software clears it.
// - SPI slave overflow sets and drops byte when buffer unread; never as master.
// - I2C receive into a full buffer sets overflow.
// - port enable routes pins to the port; clearing frees them.
// - I2C slave clock polarity bit low stretches clock; unused as master.
// - mode field picks SPI master clock source.
// - mode field picks SPI slave with or without slave select.
// - mode field picks I2C slave and master modes; some codes reserved.
// - baud counter starts on buffer write or I2C master request and stops when the operation ends.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`include "sbg_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module sbg_port
    import sbg_pkg::*;
(
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic T2_MATCH,
    input wire logic SDI,
    input wire logic SCK_IN,
    input wire logic SS_N_IN,
    input wire logic EV_START,
    input wire logic EV_STOP,
    input wire logic EV_NACK,
    input wire logic EV_ADDR_MATCH,
    input wire logic EV_RW,
    input wire logic EV_BYTE,
    input wire logic EV_BYTE_IS_DATA,
    input wire logic EV_RX,
    input wire logic [7:0] RX_DATA,
    input wire logic EV_TX_DONE,
    input wire logic EV_ADDR_UPDATE,
    input wire logic [4:0] REQ_BITS,
    output logic [7:0] TX_DATA,
    output logic SCK_O,
    output logic SCK_OE_N,
    output logic SDO_O,
    output logic SDO_OE_N,
    output logic PINS_ROUTED,
    output logic PORT_IDLE
);

    // register state
    logic smp_q, cke_q, da_q, p_q, s_q, rw_q, ua_q, bf_q;
    logic write_collision_q, ovf_q, en_q, ckp_q;
    sbg_mode_t mode_q;
    logic [7:0] reload_q, buf_q, tx_q, rx_q;
    // engine state
    sbg_spi_state_t spi_st_q;
    logic [7:0] cnt_q;
    logic pre_q, i2c_tx_q, i2c_scl_q, sck_lvl_q;
    logic [4:0] edge_q;
    logic sdi_m_q, sdi_s_q, sck_m_q, sck_s_q, sck_d_q, ss_m_q, ss_s_q;
    logic [2:0] sbit_q;
    logic seen_q;

    // mode decode
    wire spi_mst = en_q && (mode_q == SBG_M_SPI_DIV4 || mode_q == SBG_M_SPI_DIV16 ||
        mode_q == SBG_M_SPI_DIV64 || mode_q == SBG_M_SPI_T2 || mode_q == SBG_M_SPI_BRG);
    wire spi_slv = en_q && (mode_q == SBG_M_SPI_SLV_SS || mode_q == SBG_M_SPI_SLV_NOSS);
    wire i2c_mst = en_q && (mode_q == SBG_M_I2C_MHW || mode_q == SBG_M_I2C_MFW);
    wire i2c_slv = en_q && (mode_q == SBG_M_I2C_S7 || mode_q == SBG_M_I2C_S10 ||
        mode_q == SBG_M_I2C_S7SP || mode_q == SBG_M_I2C_S10SP);
    wire ten_bit = mode_q == SBG_M_I2C_S10 || mode_q == SBG_M_I2C_S10SP;
    wire i2c = i2c_mst || i2c_slv;
    wire spi = spi_mst || spi_slv;

    // register port decode
    wire wr_stat = WR && ADDR == `SBG_OFF_STAT;
    wire wr_con1 = WR && ADDR == `SBG_OFF_CON1;
    wire wr_rel = WR && ADDR == `SBG_OFF_RELOAD;
    wire wr_buf = WR && ADDR == `SBG_OFF_BUF;
    wire rd_buf = RD && ADDR == `SBG_OFF_BUF;
    wire [7:0] stat_rd = {smp_q, cke_q, da_q, p_q, s_q, rw_q, ua_q, bf_q};
    wire [7:0] con1_rd = {write_collision_q, ovf_q, en_q, ckp_q, mode_q};
    wire [7:0] rd_mux = ADDR == `SBG_OFF_STAT ? stat_rd :
        ADDR == `SBG_OFF_CON1 ? con1_rd :
        ADDR == `SBG_OFF_RELOAD ? reload_q :
        ADDR == `SBG_OFF_BUF ? buf_q : 8'h00;

    // transmit in progress blocks buffer writes
    wire slv_mid = spi_slv && sbit_q != 3'h0;
    wire busy = spi_st_q == SBG_SPI_SHIFT || i2c_tx_q || slv_mid;
    wire collide = wr_buf && busy;
    wire load = wr_buf && !busy && en_q;

    // baud counter: half-rate tick, reload on rollover
    wire [7:0] eff_reload = mode_q == SBG_M_SPI_DIV4 ? `SBG_DIV4_RELOAD :
        mode_q == SBG_M_SPI_DIV16 ? `SBG_DIV16_RELOAD :
        mode_q == SBG_M_SPI_DIV64 ? `SBG_DIV64_RELOAD : reload_q;
    wire i2c_run = i2c_mst && (i2c_tx_q || |REQ_BITS);
    wire brg_run = spi_st_q == SBG_SPI_SHIFT || i2c_run;
    wire tick = brg_run && pre_q;
    wire roll = mode_q == SBG_M_SPI_T2 ? (brg_run && T2_MATCH) : (tick && cnt_q == 8'h00);

    // SPI master edge roles
    wire lead_edge = !edge_q[0]; // even edges leave the idle level
    wire out_edge = cke_q ? !lead_edge : lead_edge;
    wire m_edge = roll && spi_mst && spi_st_q == SBG_SPI_SHIFT && edge_q <= `SBG_SPI_LAST_EDGE;
    wire m_done = roll && spi_mst && spi_st_q == SBG_SPI_SHIFT && edge_q == `SBG_SPI_DONE_EDGE;
    wire m_shift = m_edge && out_edge && !(!cke_q && edge_q == 5'h00);
    wire m_sample = smp_q ? ((m_edge && out_edge && edge_q != 5'h00) || (m_done && !cke_q))
        : (m_edge && !out_edge);

    // SPI slave edges, from the second sync flop and its delayed copy
    wire s_sel = spi_slv && (mode_q == SBG_M_SPI_SLV_NOSS || !ss_s_q);
    wire s_lead = s_sel && sck_s_q != ckp_q && sck_d_q == ckp_q;
    wire s_trail = s_sel && sck_s_q == ckp_q && sck_d_q != ckp_q;
    wire s_sample = cke_q ? s_lead : s_trail;
    wire s_shift = (cke_q ? s_trail : s_lead) && seen_q;
    wire s_done = s_sample && sbit_q == `SBG_BYTE_LAST_BIT;
    wire [7:0] rx_next = {rx_q[6:0], sdi_s_q};

    // I2C events, dead while disabled
    wire ev_start = i2c && EV_START;
    wire ev_stop = i2c && EV_STOP;
    wire i2c_rx = i2c && EV_RX;
    wire i2c_done = i2c && EV_TX_DONE;

    // status flag set/clear, set wins
    wire bf_set = m_done || (s_done && !bf_q) || (i2c_rx && !bf_q) || (load && i2c);
    wire bf_clr = rd_buf || i2c_done || !en_q;
    wire ovf_set = (s_done && bf_q) || (i2c_rx && bf_q);
    wire ovf_clr = wr_con1 && !WDATA[`SBG_CON1_OVF];
    wire write_collision_clr = wr_con1 && !WDATA[`SBG_CON1_WRITE_COLLISION];
    wire buf_from_rx = (s_done && !bf_q) || (i2c_rx && !bf_q);

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            {smp_q, cke_q} <= 2'(`SBG_STAT_RST >> 6);
            {write_collision_q, ovf_q, en_q, ckp_q} <= 4'(`SBG_CON1_RST >> 4);
            mode_q <= SBG_M_SPI_DIV4;
            reload_q <= `SBG_RELOAD_RST;
        end else begin
            if (wr_stat) begin
                smp_q <= WDATA[`SBG_STAT_SMP];
                cke_q <= WDATA[`SBG_STAT_CKE];
            end
            if (wr_con1) begin
                en_q <= WDATA[`SBG_CON1_EN];
                ckp_q <= WDATA[`SBG_CON1_CKP];
                mode_q <= sbg_mode_t'(WDATA[3:0]);
            end
            if (wr_rel) begin
                reload_q <= WDATA;
            end
            write_collision_q <= collide || (write_collision_q && !write_collision_clr);
            ovf_q <= ovf_set || (ovf_q && !ovf_clr);
        end
    end

    // I2C status bits
    always_ff @(posedge MCLK) begin
        if (!RSTN || !en_q) begin
            {da_q, p_q, s_q, rw_q, ua_q, i2c_tx_q} <= 6'h00;
        end else begin
            if (i2c && EV_BYTE) begin
                da_q <= EV_BYTE_IS_DATA;
            end
            if (ev_start) begin
                s_q <= 1'b1;
                p_q <= 1'b0;
            end else if (ev_stop) begin
                p_q <= 1'b1;
                s_q <= 1'b0;
            end
            if (i2c_mst) begin
                rw_q <= (load || i2c_tx_q) && !i2c_done;
            end else if (i2c_slv && EV_ADDR_MATCH) begin
                rw_q <= EV_RW;
            end else if (i2c_slv && (ev_start || ev_stop || EV_NACK)) begin
                rw_q <= 1'b0;
            end
            if (i2c_slv && ten_bit && EV_ADDR_UPDATE) begin
                ua_q <= 1'b1;
            end else if (wr_rel) begin
                ua_q <= 1'b0;
            end
            i2c_tx_q <= (i2c && load) || (i2c_tx_q && !i2c_done);
        end
    end

    // buffer and shift registers
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            bf_q <= 1'b0;
            buf_q <= 8'h00;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
        end else begin
            bf_q <= bf_set || (bf_q && !bf_clr);
            if (load) begin
                buf_q <= WDATA;
                tx_q <= WDATA;
            end else if (m_shift || s_shift) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (m_sample || s_sample) begin
                rx_q <= rx_next;
            end
            if (m_done) begin
                buf_q <= m_sample ? rx_next : rx_q;
            end else if (buf_from_rx) begin
                buf_q <= i2c_rx ? RX_DATA : rx_next;
            end
        end
    end

    // baud counter and SPI master sequence
    always_ff @(posedge MCLK) begin
        if (!RSTN || !en_q) begin
            spi_st_q <= SBG_SPI_IDLE;
            cnt_q <= 8'h00;
            pre_q <= 1'b0;
            edge_q <= 5'h00;
            i2c_scl_q <= 1'b1;
            sck_lvl_q <= 1'b0;
        end else begin
            if (load) begin
                cnt_q <= eff_reload;
                pre_q <= 1'b0;
            end else if (brg_run) begin
                pre_q <= !pre_q;
                if (roll) begin
                    cnt_q <= eff_reload;
                end else if (tick) begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
            if (i2c_run && roll) begin
                i2c_scl_q <= !i2c_scl_q;
            end
            case (spi_st_q)
                SBG_SPI_IDLE: begin
                    sck_lvl_q <= ckp_q;
                    edge_q <= 5'h00;
                    if (load && spi_mst) begin
                        spi_st_q <= SBG_SPI_SHIFT;
                    end
                end
                SBG_SPI_SHIFT: begin
                    if (m_edge) begin
                        sck_lvl_q <= !sck_lvl_q;
                    end
                    if (roll) begin
                        edge_q <= edge_q + 5'h01;
                    end
                    if (m_done) begin
                        spi_st_q <= SBG_SPI_IDLE;
                    end
                end
                default: begin
                    spi_st_q <= SBG_SPI_IDLE;
                end
            endcase
        end
    end

    // pin synchronisers and SPI slave bit count
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            {sdi_m_q, sdi_s_q, sck_m_q, sck_s_q, sck_d_q} <= 5'h00;
            {ss_m_q, ss_s_q} <= 2'h3;
            sbit_q <= 3'h0;
            seen_q <= 1'b0;
        end else begin
            sdi_m_q <= SDI;
            sdi_s_q <= sdi_m_q;
            sck_m_q <= SCK_IN;
            sck_s_q <= sck_m_q;
            sck_d_q <= sck_s_q;
            ss_m_q <= SS_N_IN;
            ss_s_q <= ss_m_q;
            if (!s_sel) begin
                sbit_q <= 3'h0;
                seen_q <= 1'b0;
            end else if (s_sample) begin
                sbit_q <= sbit_q + 3'h1;
                seen_q <= !s_done;
            end
        end
    end

    // registered outputs
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
            TX_DATA <= 8'h00;
            {SCK_O, SCK_OE_N, SDO_O, SDO_OE_N} <= 4'hf;
            PINS_ROUTED <= 1'b0;
            PORT_IDLE <= 1'b1;
        end else begin
            RDATA <= RD ? rd_mux : 8'h00;
            TX_DATA <= buf_q;
            PINS_ROUTED <= en_q;
            PORT_IDLE <= !(rw_q || |REQ_BITS);
            SCK_O <= spi_mst ? sck_lvl_q : i2c_mst ? i2c_scl_q : !i2c_slv;
            SCK_OE_N <= spi_mst ? 1'b0 : i2c_mst ? i2c_scl_q : i2c_slv ? ckp_q : 1'b1;
            SDO_O <= tx_q[7];
            SDO_OE_N <= !(spi_mst || s_sel);
        end
    end

    // assertion helpers: cycles between baud rollovers in reload mode
    logic [9:0] gap_q;
    logic gap_ok_q;
    always_ff @(posedge MCLK) begin
        if (!RSTN || load || !brg_run) begin
            gap_q <= 10'h000;
            gap_ok_q <= 1'b0;
        end else if (roll) begin
            gap_q <= 10'h000;
            gap_ok_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 10'h001;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    property p_half_period;
        (roll && gap_ok_q && (mode_q == SBG_M_SPI_BRG || i2c_mst) && !$past(wr_rel))
            |-> gap_q == 10'(2 * reload_q + 1);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("baud half period wrong");

    property p_write_collision;
        wr_buf && busy |=> write_collision_q ##1 (write_collision_q || $past(write_collision_clr));
    endproperty
    a_write_collision: assert property (p_write_collision)
        else $error("write collision not held");

    property p_no_master_ovf;
        $rose(ovf_q) |-> !$past(spi_mst);
    endproperty
    a_no_master_ovf: assert property (p_no_master_ovf)
        else $error("overflow set in SPI master");

    property p_sp_disabled;
        !en_q |=> !s_q && !p_q;
    endproperty
    a_sp_disabled: assert property (p_sp_disabled)
        else $error("start/stop flag set while disabled");

    property p_start_last;
        en_q && i2c && EV_START |=> s_q && !p_q;
    endproperty
    a_start_last: assert property (p_start_last)
        else $error("start not recorded last");

    property p_busy_not_idle;
        i2c_mst && load |=> ##1 !PORT_IDLE;
    endproperty
    a_busy_not_idle: assert property (p_busy_not_idle)
        else $error("idle shown during transmit");

    property p_idle_level;
        (spi_mst && spi_st_q == SBG_SPI_IDLE && $stable(ckp_q)) [*3] |-> SCK_O == ckp_q;
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("SPI clock idle level wrong");

    property p_stretch;
        i2c_slv && !ckp_q |=> SCK_OE_N == 1'b0 && SCK_O == 1'b0;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock not stretched");

    property p_pins_off;
        !en_q |=> SCK_OE_N && SDO_OE_N && !PINS_ROUTED;
    endproperty
    a_pins_off: assert property (p_pins_off)
        else $error("pins driven while disabled");

    property p_i2c_rx;
        i2c && EV_RX && !bf_q |=> bf_q && buf_q == $past(RX_DATA);
    endproperty
    a_i2c_rx: assert property (p_i2c_rx)
        else $error("received byte not buffered");

    property p_i2c_ovf;
        i2c && EV_RX && bf_q && !rd_buf |=> ovf_q && $stable(buf_q);
    endproperty
    a_i2c_ovf: assert property (p_i2c_ovf)
        else $error("overflow not flagged");

endmodule // sbg_port

`default_nettype wire

// [bench/sbg_spi_peer.sv]
// Purpose: behavioural SPI slave peer on the master clock and data pins
// Assumes: LOAD rises before each frame; a frame is sixteen clock edges
// Notes: edges outside a frame are ignored
`timescale 1ns/10ps
`default_nettype none

module sbg_spi_peer (
    input wire logic SCK,
    input wire logic CPOL,
    input wire logic CKE,
    input wire logic LOAD,
    input wire logic SDO,
    input wire logic [7:0] TX,
    output logic SDI,
    output logic [7:0] RX
);
    logic [7:0] sh = 8'h00;
    int cnt = 16;
    initial SDI = 1'b0;
    initial RX = 8'h00;
    always @(posedge LOAD) begin
        sh = TX;
        SDI = TX[7];
        RX = 8'h00;
        cnt = 0;
    end
    // shift on the master's shift edges, never on the first edge of a frame
    always @(SCK) begin
        if (cnt < 16) begin
            if ((SCK == CPOL) == CKE) begin
                if (cnt != 0) begin
                    sh = sh << 1;
                    SDI = sh[7];
                end
            end else begin
                RX = {RX[6:0], SDO};
            end
            cnt++;
        end
    end
endmodule // sbg_spi_peer

`default_nettype wire

// [bench/sbg_port_tb.sv]
// Purpose: self-checking bench for the serial port clock and status block
// Assumes: one-cycle register strobes; SPI peer model on the master pins
// Notes: expectations follow the status and control register bit layout
`timescale 1ns/10ps
`default_nettype none

module sbg_port_tb
    import sbg_pkg::*;
;
    logic mclk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, t2 = 1'b0, sck_in = 1'b0;
    logic ev_rw = 1'b0, ev_data = 1'b0, tb_sdi = 1'b0, slv = 1'b0, cpol = 1'b0, cke = 1'b0;
    logic load = 1'b0, ss_n = 1'b1;
    logic [2:0] addr = 3'h0, t2c = 3'h0;
    logic [4:0] req = 5'h00;
    logic [7:0] wdata = 8'h00, rx_data = 8'h00, ev = 8'h00, ptx = 8'h00;
    wire logic [7:0] rdata, tx_data, prx;
    wire logic sck_o, sck_oe_n, sdo_o, sdo_oe_n, routed, idle, peer_sdi;
    wire logic sdi = slv ? tb_sdi : peer_sdi;
    wire logic sck_pin = sck_oe_n ? 1'b1 : sck_o;
    int err_count = 0, n_tests = 0;

    always #10 mclk = ~mclk;
    // timer match pulse every six cycles
    always @(posedge mclk) begin
        t2c <= (t2c == 3'h5) ? 3'h0 : t2c + 3'h1;
        t2 <= (t2c == 3'h5);
    end

    sbg_port DUT (.MCLK(mclk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .T2_MATCH(t2), .SDI(sdi), .SCK_IN(sck_in),
        .SS_N_IN(ss_n), .EV_START(ev[0]), .EV_STOP(ev[1]), .EV_NACK(ev[2]),
        .EV_ADDR_MATCH(ev[3]), .EV_RW(ev_rw), .EV_BYTE(ev[4]), .EV_BYTE_IS_DATA(ev_data),
        .EV_RX(ev[5]), .RX_DATA(rx_data), .EV_TX_DONE(ev[6]), .EV_ADDR_UPDATE(ev[7]),
        .REQ_BITS(req), .TX_DATA(tx_data), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n),
        .SDO_O(sdo_o), .SDO_OE_N(sdo_oe_n), .PINS_ROUTED(routed), .PORT_IDLE(idle));
    sbg_spi_peer peer (.SCK(sck_pin), .CPOL(cpol), .CKE(cke), .LOAD(load), .SDO(sdo_o),
        .TX(ptx), .SDI(peer_sdi), .RX(prx));

    task automatic complete_run();
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(nm, e, d);
    endtask
    task automatic pulse(input int i);
        @(posedge mclk);
        ev[i] <= 1'b1;
        @(posedge mclk);
        ev <= 8'h00;
    endtask
    // third toggle gap: the first two may be partial or the shortened first half
    task automatic half(input string nm, input int e);
        logic s;
        int n;
        for (int k = 0; k < 3; k++) begin
            s = sck_o;
            n = 0;
            while (sck_o === s && n < 2000) begin
                @(posedge mclk);
                n++;
            end
        end
        chk(nm, e[7:0], n[7:0]);
        if (n >= 2000) complete_run();
    endtask
    task automatic spi(input sbg_mode_t m, input logic p, input logic k, input logic s,
        input int e);
        logic [7:0] t, d;
        int n;
        t = {m, p, k, s, 1'b1} ^ 8'h96;
        cpol = p;
        cke = k;
        ptx = ~t;
        wr(3'h1, {3'b001, p, m});
        wr(3'h0, {s, k, 6'h00});
        repeat (4) @(posedge mclk);
        chk("sck idle", {7'h00, p}, {7'h00, sck_o});
        chk("routed", 8'h01, {7'h00, routed});
        chk("sdo drive", 8'h00, {7'h00, sdo_oe_n});
        load <= 1'b1;
        wr(3'h3, t);
        load <= 1'b0;
        wr(3'h3, 8'h00);
        half("spi half", e);
        d = 8'h00;
        n = 0;
        while (d[0] !== 1'b1 && n < 400) begin
            rd(3'h0, d);
            n++;
        end
        chk("bf set", 8'h01, {7'h00, d[0]});
        if (d[0] !== 1'b1) complete_run();
        rchk("rx buffer", 3'h3, ~t);
        chk("peer rx", t, prx);
        rchk("bf clear", 3'h0, {s, k, 6'h00});
        rchk("collision", 3'h1, {3'b101, p, m});
        wr(3'h1, {3'b001, p, m});
        rchk("col clear", 3'h1, {3'b001, p, m});
        wr(3'h1, 8'h00);
    endtask
    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            tb_sdi <= b[i];
            repeat (6) @(posedge mclk);
            sck_in <= 1'b1;
            repeat (6) @(posedge mclk);
            sck_in <= 1'b0;
        end
        repeat (8) @(posedge mclk);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rchk("status rst", 3'h0, 8'h00);
        rchk("con1 rst", 3'h1, 8'h00);
        rchk("reload rst", 3'h2, 8'h00);
        chk("idle rst", 8'h01, {7'h00, idle});
        wr(3'h5, 8'hff);
        rchk("unmapped", 3'h5, 8'h00);
        wr(3'h0, 8'hff);
        rchk("status ro", 3'h0, 8'hc0);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'hc0);
        rchk("con1 set", 3'h1, 8'h00);
        spi(SBG_M_SPI_DIV4, 1'b0, 1'b0, 1'b1, 2);
        spi(SBG_M_SPI_DIV16, 1'b1, 1'b0, 1'b0, 8);
        spi(SBG_M_SPI_DIV64, 1'b0, 1'b1, 1'b0, 32);
        wr(3'h2, 8'h04);
        spi(SBG_M_SPI_BRG, 1'b1, 1'b1, 1'b1, 10);
        spi(SBG_M_SPI_T2, 1'b0, 1'b1, 1'b0, 6);
        slv <= 1'b1;
        wr(3'h1, {4'b0010, SBG_M_SPI_SLV_NOSS});
        wr(3'h0, 8'h40);
        sbyte(8'h3c);
        sbyte(8'h96);
        rchk("spi ovf", 3'h1, 8'h65);
        rchk("slave buf", 3'h3, 8'h3c);
        rchk("slave bf", 3'h0, 8'h40);
        wr(3'h1, {4'b0010, SBG_M_SPI_SLV_SS});
        sbyte(8'h5a);
        rchk("ss high", 3'h0, 8'h40);
        ss_n <= 1'b0;
        sbyte(8'ha5);
        rchk("ss low", 3'h3, 8'ha5);
        ss_n <= 1'b1;
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h00);
        slv <= 1'b0;
        wr(3'h1, {4'b0010, SBG_M_I2C_MHW});
        wr(3'h2, 8'h03);
        req <= 5'h08;
        half("i2c half", 8);
        chk("req busy", 8'h00, {7'h00, idle});
        req <= 5'h00;
        pulse(0);
        rchk("start", 3'h0, 8'h08);
        pulse(1);
        rchk("stop", 3'h0, 8'h10);
        ev_data <= 1'b1;
        pulse(4);
        rchk("data", 3'h0, 8'h30);
        ev_data <= 1'b0;
        wr(3'h3, 8'h55);
        wr(3'h3, 8'haa);
        rchk("tx status", 3'h0, 8'h35);
        chk("tx data", 8'h55, tx_data);
        chk("tx busy", 8'h00, {7'h00, idle});
        pulse(6);
        rchk("tx done", 3'h0, 8'h30);
        chk("tx idle", 8'h01, {7'h00, idle});
        rchk("i2c col", 3'h1, 8'ha8);
        wr(3'h1, 8'h00);
        rchk("off status", 3'h0, 8'h00);
        chk("unrouted", 8'h00, {7'h00, routed});
        chk("sdo free", 8'h01, {7'h00, sdo_oe_n});
        wr(3'h1, {4'b0010, SBG_M_I2C_S10});
        ev_rw <= 1'b1;
        pulse(3);
        pulse(7);
        rchk("match", 3'h0, 8'h06);
        chk("stretch", 8'h00, {6'h00, sck_oe_n, sck_o});
        wr(3'h2, 8'h10);
        rchk("ua clear", 3'h0, 8'h04);
        rx_data <= 8'h81;
        pulse(5);
        rx_data <= 8'h42;
        pulse(5);
        rchk("i2c ovf", 3'h1, 8'h67);
        rchk("i2c buf", 3'h3, 8'h81);
        wr(3'h1, 8'h37);
        rchk("release", 3'h1, 8'h37);
        chk("released", 8'h01, {7'h00, sck_oe_n});
        wr(3'h1, {4'b0011, SBG_M_I2C_S7SP});
        pulse(7);
        rchk("ua 7bit", 3'h0, 8'h04);
        wr(3'h1, {4'b0010, SBG_M_RSVC});
        rchk("rsv mode", 3'h1, 8'h2c);
        chk("rsv pins", 8'h03, {6'h00, sck_oe_n, sdo_oe_n});
        wr(3'h1, 8'h00);
        complete_run();
    end
endmodule // sbg_port_tb

`default_nettype wire
